// >>> include/pfm_pkg.sv
// Package for the predictive failure monitor: constants and carrier types
package pfm_pkg;
    // Attribute count and counter widths
    localparam int PFM_NUM_ATTR = 4;
    localparam int PFM_CNT_W = 16;
    localparam int PFM_HIST_W = 8;
    // Clock rate and time constants
    localparam longint PFM_CLK_HZ = 40000000;
    localparam longint PFM_MEAS_PERIOD_S = 3600;
    localparam longint PFM_MEAS_PERIOD_CYC = PFM_MEAS_PERIOD_S * PFM_CLK_HZ;
    localparam longint PFM_MAX_DELAY_MS = 75;
    localparam longint PFM_MAX_DELAY_CYC = (PFM_MAX_DELAY_MS * PFM_CLK_HZ) / 1000;
    localparam int PFM_TIMER_W = 40;
    // Idle time required before a deferred save may start
    localparam int PFM_IDLE_CYC = 16;
    localparam int PFM_IDLE_W = 8;
    // Measurement and save duration in cycles (whole save run)
    localparam int PFM_SAVE_CYC = 64;
    localparam int PFM_SAVE_W = 8;
    // Reset values
    localparam logic [PFM_CNT_W-1:0] PFM_CNT_RST = 16'h0000;
    localparam logic [PFM_HIST_W-1:0] PFM_HIST_RST = 8'h00;
    // Report method and sense code
    localparam logic [3:0] PFM_EXCEPTION_REPORT_METHOD_SENSE = 4'h1;
    localparam logic [23:0] PFM_SENSE_PRED_FAIL = 24'h015D00;
    localparam logic [23:0] PFM_SENSE_NONE = 24'h000000;

    // Per-attribute configuration
    typedef struct packed {
        logic [PFM_CNT_W-1:0] interval_len;
        logic [PFM_CNT_W-1:0] err_threshold;
        logic [PFM_HIST_W-1:0] pred_threshold;
    } pfm_cfg_t;

    // Per-attribute status
    typedef struct packed {
        logic [PFM_CNT_W-1:0] interval_cnt;
        logic [PFM_CNT_W-1:0] fail_cnt;
        logic [PFM_HIST_W-1:0] hist_cnt;
        logic pred_fail;
    } pfm_stat_t;

    // Off-line measurement sequencer states
    typedef enum logic [2:0] {
        PFM_ST_WAIT = 3'b001,
        PFM_ST_IDLEW = 3'b010,
        PFM_ST_SAVE = 3'b100
    } pfm_state_t;
endpackage : pfm_pkg

// >>> hw/pfm_monitor.sv
// Predictive failure monitor: per-attribute rate counters, hourly save, reporting
//
// Overview of operation
// R01 - Exception disable turns off every monitoring function.
// R02 - While enabled, count on-line data during normal reads and writes.
// R03 - Online-only select skips all off-line measurement work.
// R04 - Force command measures, saves, and restarts the one-hour timer.
// R05 - Report time remaining until the next scheduled measurement.
// R06 - Measure and save hourly, deferred until host interfaces are idle.
// R07 - An arriving host operation aborts the off-line save; a force command in the same cycle keeps the save running here.
// R08 - On-line monitor work never delays host operations beyond 75 ms.
// R09 - Report method one sends predictive failure sense code with failure type.
// R10 - Reported failure code is kept across bus resets and power cycles.
// R11 - Interval counter counts operations; interval length sets window size.
// R12 - Failure counter counts errors within the current interval.
// R13 - Errors above threshold before expiry: unacceptable; else acceptable at expiry.
// R14 - After each classification clear interval and failure counters.
// R15 - History counter up on unacceptable, down on acceptable, floor zero.
// R16 - History reaching predictive threshold signals predictive failure.
// R17 - Each attribute has its own independent counters.
// R18 - Per-attribute thresholds in config registers; counters saturate.
`timescale 1ns/1ps
`default_nettype none
module pfm_monitor
    import pfm_pkg::*;
#(
    parameter int NUM_ATTR = PFM_NUM_ATTR,
    parameter longint MEAS_PERIOD_CYC = PFM_MEAS_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic exception_disable,
    input wire logic online_only_select,
    input wire logic [3:0] exception_report_method,
    input wire logic force_measurement_command,
    input wire logic host_busy,
    input wire logic [NUM_ATTR-1:0] attr_op,
    input wire logic [NUM_ATTR-1:0] attr_err,
    input wire logic [NUM_ATTR-1:0] cfg_we,
    input wire pfm_cfg_t cfg_wdata,
    input wire logic [23:0] nv_sense_in,
    input wire logic [7:0] nv_fru_in,
    output pfm_stat_t [NUM_ATTR-1:0] attr_status,
    output logic [PFM_TIMER_W-1:0] time_remaining,
    output logic save_active,
    output logic save_done,
    output logic save_aborted,
    output logic sense_valid,
    output logic [23:0] sense_code,
    output logic [7:0] sense_fru,
    output logic nv_write
);
    localparam logic [PFM_TIMER_W-1:0] PERIOD = PFM_TIMER_W'(MEAS_PERIOD_CYC);
    localparam logic [PFM_TIMER_W-1:0] ONE_T = {{(PFM_TIMER_W-1){1'b0}}, 1'b1};
    localparam logic [PFM_CNT_W-1:0] CNT_MAX = {PFM_CNT_W{1'b1}};
    localparam logic [PFM_HIST_W-1:0] HIST_MAX = {PFM_HIST_W{1'b1}};
    // Saturation ceilings for the counters. Holding at the top rather than
    // wrapping keeps a long error burst from looking like a clean window.

    // Monitoring on when not disabled
    wire mon_en = ~exception_disable; // R01
    wire offline_en = mon_en & ~online_only_select; // R03

    pfm_cfg_t cfg_reg [NUM_ATTR];
    pfm_stat_t [NUM_ATTR-1:0] stat_reg;
    wire [NUM_ATTR-1:0] new_fail;

    // Independent counter set per attribute; one-cycle update keeps host delay far
    // below the 75 ms ceiling since nothing here stalls host traffic
    genvar g;
    generate
        for (g = 0; g < NUM_ATTR; g++) begin : g_attr // R17
            wire op = mon_en & attr_op[g]; // R02
            wire er = mon_en & attr_err[g]; // R02
            wire [PFM_CNT_W-1:0] ic_inc = (stat_reg[g].interval_cnt == CNT_MAX) ?
                CNT_MAX : stat_reg[g].interval_cnt + 1'b1; // R18
            wire [PFM_CNT_W-1:0] fc_inc = (stat_reg[g].fail_cnt == CNT_MAX) ?
                CNT_MAX : stat_reg[g].fail_cnt + 1'b1; // R18
            wire [PFM_CNT_W-1:0] ic_now = op ? ic_inc : stat_reg[g].interval_cnt; // R11
            wire [PFM_CNT_W-1:0] fc_now = er ? fc_inc : stat_reg[g].fail_cnt; // R12
            wire unacc = fc_now > cfg_reg[g].err_threshold; // R13
            wire expired = ic_now >= cfg_reg[g].interval_len; // R11
            wire acc = expired & ~unacc; // R13
            wire classify = mon_en & (unacc | expired);
            wire [PFM_HIST_W-1:0] h = stat_reg[g].hist_cnt;
            wire [PFM_HIST_W-1:0] h_next = unacc ? ((h == HIST_MAX) ? HIST_MAX : h + 1'b1) :
                (acc ? ((h == '0) ? '0 : h - 1'b1) : h); // R15 R18
            wire pf_next = stat_reg[g].pred_fail |
                (classify & (h_next >= cfg_reg[g].pred_threshold)); // R16
            assign new_fail[g] = pf_next & ~stat_reg[g].pred_fail;

            // Config register write
            always_ff @(posedge clk) begin
                if (rst) begin
                    cfg_reg[g] <= '0;
                end else if (cfg_we[g]) begin
                    cfg_reg[g] <= cfg_wdata; // R18
                end
            end

            // Counter update; both counters cleared on classification
            always_ff @(posedge clk) begin
                if (rst) begin
                    stat_reg[g] <= '0;
                end else if (mon_en) begin
                    stat_reg[g].interval_cnt <= classify ? PFM_CNT_RST : ic_now; // R14
                    stat_reg[g].fail_cnt <= classify ? PFM_CNT_RST : fc_now; // R14
                    if (classify) begin
                        stat_reg[g].hist_cnt <= h_next; // R15
                    end
                    stat_reg[g].pred_fail <= pf_next; // R16
                end
            end
        end
    endgenerate
    assign attr_status = stat_reg;

    // Off-line measurement sequencer
    // WAIT counts down the hourly timer, IDLEW waits for a quiet host, SAVE
    // runs the measurement. Host traffic wins over a running save unless a force
    // command arrives in the same cycle, so the save may restart several times before it completes.
    pfm_state_t state_reg, state_next;
    logic [PFM_TIMER_W-1:0] timer_reg, timer_next;
    logic [PFM_IDLE_W-1:0] idle_reg;
    logic [PFM_SAVE_W-1:0] save_reg;
    logic done_reg, abort_reg;

    wire timer_expired = (timer_reg == '0);
    wire idle_ok = (idle_reg >= PFM_IDLE_W'(PFM_IDLE_CYC));
    wire save_fin = (save_reg >= PFM_SAVE_W'(PFM_SAVE_CYC - 1));
    wire forced = force_measurement_command & offline_en; // R04
    wire abort_now = (state_reg == PFM_ST_SAVE) & host_busy & ~forced; // R07

    // Next state; a forced measurement runs at once and is not deferred
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFM_ST_WAIT: begin
                if (forced) begin
                    state_next = PFM_ST_SAVE; // R04
                end else if (offline_en & timer_expired) begin
                    state_next = PFM_ST_IDLEW; // R06
                end
            end
            PFM_ST_IDLEW: begin
                if (forced) begin
                    state_next = PFM_ST_SAVE;
                end else if (idle_ok) begin
                    state_next = PFM_ST_SAVE; // R06
                end
            end
            PFM_ST_SAVE: begin
                if (abort_now) begin
                    state_next = PFM_ST_IDLEW; // R07
                end else if (save_fin) begin
                    state_next = PFM_ST_WAIT;
                end
            end
            default: state_next = PFM_ST_WAIT;
        endcase
        if (!offline_en) begin
            state_next = PFM_ST_WAIT; // R03
        end
    end

    // Hourly countdown; reload on force and on completed save
    always_comb begin
        timer_next = timer_reg;
        if (forced) begin
            timer_next = PERIOD - ONE_T; // R04
        end else if (state_reg == PFM_ST_SAVE && save_fin && !abort_now) begin
            timer_next = PERIOD - ONE_T; // R06
        end else if (!timer_expired && offline_en) begin
            timer_next = timer_reg - ONE_T;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= PFM_ST_WAIT;
            timer_reg <= PERIOD - ONE_T;
            idle_reg <= '0;
            save_reg <= '0;
            done_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            // Idle run length; saturates at threshold
            idle_reg <= host_busy ? '0 : (idle_ok ? idle_reg : idle_reg + 1'b1); // R06
            save_reg <= (state_next == PFM_ST_SAVE && state_reg == PFM_ST_SAVE) ?
                save_reg + 1'b1 : '0;
            done_reg <= (state_reg == PFM_ST_SAVE) & save_fin & ~abort_now;
            abort_reg <= abort_now; // R07
        end
    end

    assign time_remaining = timer_reg; // R05
    assign save_active = (state_reg == PFM_ST_SAVE);
    assign save_done = done_reg;
    assign save_aborted = abort_reg;

    // Failure type: lowest attribute that newly failed
    // Only one type fits the report, so simultaneous failures of several
    // attributes report the lowest; the others stay visible in their status.
    logic [7:0] fru_new;
    always_comb begin
        fru_new = 8'h00;
        for (int i = NUM_ATTR - 1; i >= 0; i--) begin
            if (new_fail[i]) begin
                fru_new = 8'(i + 1);
            end
        end
    end

    // Sense report; restored from nonvolatile copy after reset so it survives
    // bus resets and power cycles, and written back on every new report
    logic [23:0] sense_reg;
    logic [7:0] fru_reg;
    logic nvw_reg, loaded_reg;
    wire report = mon_en & (exception_report_method == PFM_EXCEPTION_REPORT_METHOD_SENSE) & (|new_fail); // R09
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_reg <= PFM_SENSE_NONE;
            fru_reg <= 8'h00;
            nvw_reg <= 1'b0;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            // A failure raised in the load cycle must not be lost: it beats
            // the stored copy and is written back like any other report
            sense_reg <= report ? PFM_SENSE_PRED_FAIL : nv_sense_in; // R10
            fru_reg <= report ? fru_new : nv_fru_in; // R10
            loaded_reg <= 1'b1;
            nvw_reg <= report;
        end else begin
            nvw_reg <= report; // R10
            if (report) begin
                sense_reg <= PFM_SENSE_PRED_FAIL; // R09
                fru_reg <= fru_new; // R09
            end
        end
    end
    // Report outputs straight from their registers
    // sense_valid is a plain compare so a restored report shows at once
    assign sense_code = sense_reg;
    assign sense_fru = fru_reg;
    assign sense_valid = (sense_reg != PFM_SENSE_NONE);
    assign nv_write = nvw_reg;
endmodule : pfm_monitor
`default_nettype wire

// >>> verification/pfm_nv_model.sv
// Nonvolatile store model beside the monitor
`timescale 1ns/1ps
`default_nettype none
module pfm_nv_model
    import pfm_pkg::*;
(
    input wire logic clk,
    input wire logic nv_write,
    input wire logic [23:0] sense_code,
    input wire logic [7:0] sense_fru,
    output logic [23:0] nv_sense,
    output logic [7:0] nv_fru
);
    // Blank store at power-up
    initial begin
        nv_sense = PFM_SENSE_NONE;
        nv_fru = 8'h00;
    end
    // No reset here, as the copy must outlive device resets
    always @(posedge clk) begin
        if (nv_write) begin
            nv_sense <= sense_code;
            nv_fru <= sense_fru;
        end
    end
endmodule : pfm_nv_model
`default_nettype wire

// >>> verification/pfm_monitor_sva.sv
// Port checker for attribute 0 and the sequencer
`timescale 1ns/1ps
`default_nettype none
module pfm_monitor_chk
    import pfm_pkg::*;
#(
    parameter int NUM_ATTR = 2,
    parameter longint MEAS_PERIOD_CYC = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic exception_disable,
    input wire logic online_only_select,
    input wire logic [3:0] exception_report_method,
    input wire logic force_measurement_command,
    input wire logic host_busy,
    input wire logic [NUM_ATTR-1:0] attr_op,
    input wire logic [NUM_ATTR-1:0] attr_err,
    input wire logic [NUM_ATTR-1:0] cfg_we,
    input wire pfm_cfg_t cfg_wdata,
    input wire pfm_stat_t [NUM_ATTR-1:0] attr_status,
    input wire logic [PFM_TIMER_W-1:0] time_remaining,
    input wire logic save_active,
    input wire logic save_aborted,
    input wire logic [23:0] sense_code,
    input wire logic nv_write
);
    pfm_cfg_t cfg_reg;
    pfm_stat_t s;
    logic go;
    logic bad;
    // Shadow config, since the design keeps it inside
    always_ff @(posedge clk) begin
        if (rst) cfg_reg <= '0;
        else if (cfg_we[0]) cfg_reg <= cfg_wdata;
    end
    // Error that pushes the count over the threshold
    assign s = attr_status[0];
    assign go = !exception_disable && !cfg_we[0];
    assign bad = go && attr_err[0] && ({1'b0, s.fail_cnt} + 17'h1 > {1'b0, cfg_reg.err_threshold});
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    freeze_off_a: assert property (exception_disable |=> $stable(s))
        else $error("status moved while disabled");
    op_count_a: assert property (go && attr_op[0] && !attr_err[0] && !bad &&
        {1'b0, s.interval_cnt} + 17'h1 < {1'b0, cfg_reg.interval_len}
        |=> s.interval_cnt == $past(s.interval_cnt) + 16'h1) else $error("op not counted");
    bad_clear_a: assert property (bad |=> s.interval_cnt == 16'h0 && s.fail_cnt == 16'h0)
        else $error("counters kept after bad window");
    hist_up_a: assert property (bad |=> s.hist_cnt ==
        ($past(s.hist_cnt) == 8'hFF ? 8'hFF : $past(s.hist_cnt) + 8'h1)) else $error("hist not up");
    pred_set_a: assert property ($changed(s.hist_cnt) &&
        s.hist_cnt >= cfg_reg.pred_threshold |-> s.pred_fail) else $error("pred not set");
    report_a: assert property ($rose(s.pred_fail) && exception_report_method == PFM_EXCEPTION_REPORT_METHOD_SENSE
        |-> sense_code == PFM_SENSE_PRED_FAIL && nv_write) else $error("no sense report");
    force_a: assert property (force_measurement_command && go && !online_only_select
        |=> save_active && time_remaining == PFM_TIMER_W'(MEAS_PERIOD_CYC - 1))
        else $error("force not taken");
    abort_a: assert property (save_active && host_busy && !force_measurement_command
        |=> !save_active ##[0:1] save_aborted) else $error("save not aborted");
endmodule : pfm_monitor_chk
bind pfm_monitor pfm_monitor_chk #(.NUM_ATTR(NUM_ATTR), .MEAS_PERIOD_CYC(MEAS_PERIOD_CYC)) chk_u (
    .clk(clk), .rst(rst), .exception_disable(exception_disable),
    .online_only_select(online_only_select), .exception_report_method(exception_report_method),
    .force_measurement_command(force_measurement_command), .host_busy(host_busy),
    .attr_op(attr_op), .attr_err(attr_err), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
    .attr_status(attr_status), .time_remaining(time_remaining), .save_active(save_active),
    .save_aborted(save_aborted), .sense_code(sense_code), .nv_write(nv_write));
`default_nettype wire

// >>> verification/pfm_monitor_bench.sv
// Self-checking bench for the predictive failure monitor
`timescale 1ns/1ps
`default_nettype none
module pfm_monitor_bench
    import pfm_pkg::*;
;
    localparam longint PER = 200;
    logic clk, rst, exception_disable, online_only_select, force_measurement_command, host_busy;
    logic save_active, save_done, save_aborted, nv_write, sense_valid;
    logic [3:0] exception_report_method;
    logic [1:0] attr_op, attr_err, cfg_we;
    logic [23:0] nv_sense_in, sense_code;
    logic [7:0] nv_fru_in, sense_fru;
    logic [PFM_TIMER_W-1:0] time_remaining, tr;
    pfm_cfg_t cfg_wdata;
    pfm_stat_t [1:0] attr_status;
    int mismatches = 0;
    int comparisons = 0;
    int aborts = 0;
    int dones = 0;
    pfm_monitor #(.NUM_ATTR(2), .MEAS_PERIOD_CYC(PER)) dut_u (.clk(clk), .rst(rst),
        .exception_disable(exception_disable), .online_only_select(online_only_select),
        .exception_report_method(exception_report_method), .host_busy(host_busy),
        .force_measurement_command(force_measurement_command), .attr_op(attr_op),
        .attr_err(attr_err), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .nv_fru_in(nv_fru_in),
        .nv_sense_in(nv_sense_in), .attr_status(attr_status), .save_done(save_done),
        .time_remaining(time_remaining), .save_active(save_active), .sense_valid(sense_valid),
        .save_aborted(save_aborted), .sense_code(sense_code), .sense_fru(sense_fru),
        .nv_write(nv_write));
    pfm_nv_model nv_u (.clk(clk), .nv_write(nv_write), .sense_code(sense_code),
        .sense_fru(sense_fru), .nv_sense(nv_sense_in), .nv_fru(nv_fru_in));
    // Clock and pulse counters; counting avoids missing one-cycle pulses
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (save_aborted === 1'b1) aborts++;
        if (save_done === 1'b1) dones++;
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic pulse_attr(input int i, input logic op, input logic err);
        @(negedge clk);
        attr_op[i] = op;
        attr_err[i] = err;
        @(negedge clk);
        attr_op = 2'h0;
        attr_err = 2'h0;
    endtask : pulse_attr
    task automatic write_cfg(input int i, input pfm_cfg_t c);
        @(negedge clk);
        cfg_we[i] = 1'b1;
        cfg_wdata = c;
        @(negedge clk);
        cfg_we = 2'h0;
    endtask : write_cfg
    task automatic do_reset;
        @(negedge clk);
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset
    task automatic results;
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // Watchdog at 4000 cycles, well past the 176 cycles the sequence needs
    initial begin
        #100000;
        mismatches++;
        results;
    end
    initial begin
        // Stay disabled until configured: an all-zero config fails at once
        {rst, exception_disable, online_only_select, force_measurement_command} = 4'hC;
        {host_busy, attr_op, attr_err, cfg_we} = 7'h00;
        exception_report_method = PFM_EXCEPTION_REPORT_METHOD_SENSE;
        cfg_wdata = '0;
        do_reset;
        write_cfg(0, {16'h0004, 16'h0001, 8'h02});
        write_cfg(1, {16'h0008, 16'h0005, 8'h03});
        exception_disable = 1'b0;
        tr = time_remaining;
        repeat (10) @(negedge clk);
        check(time_remaining, tr - 40'h0A);
        pulse_attr(0, 1'b1, 1'b0);
        pulse_attr(0, 1'b1, 1'b0);
        check(attr_status[0].interval_cnt, 40'h2);
        pulse_attr(0, 1'b1, 1'b1);
        check(attr_status[0].fail_cnt, 40'h1);
        check(attr_status[1].interval_cnt, 40'h0);
        pulse_attr(0, 1'b1, 1'b0);
        check(attr_status[0].interval_cnt, 40'h0);
        check(attr_status[0].hist_cnt, 40'h0);
        repeat (4) pulse_attr(0, 1'b0, 1'b1);
        check(attr_status[0].hist_cnt, 40'h2);
        check(attr_status[0].pred_fail, 40'h1);
        @(negedge clk);
        check(sense_code, PFM_SENSE_PRED_FAIL);
        check(sense_fru, 40'h1);
        check(sense_valid, 40'h1);
        exception_disable = 1'b1;
        pulse_attr(1, 1'b1, 1'b1);
        check(attr_status[1].interval_cnt, 40'h0);
        exception_disable = 1'b0;
        pulse_attr(1, 1'b1, 1'b1);
        check(attr_status[1].fail_cnt, 40'h1);
        @(negedge clk);
        force_measurement_command = 1'b1;
        @(negedge clk);
        force_measurement_command = 1'b0;
        check(save_active, 40'h1);
        check(time_remaining, PER - 1);
        host_busy = 1'b1;
        repeat (3) @(negedge clk);
        host_busy = 1'b0;
        check(aborts, 40'h1);
        repeat (100) @(negedge clk);
        check(dones, 40'h1);
        online_only_select = 1'b1;
        @(negedge clk);
        tr = time_remaining;
        repeat (20) @(negedge clk);
        check(time_remaining, tr);
        online_only_select = 1'b0;
        exception_disable = 1'b1;
        do_reset;
        @(negedge clk);
        check(sense_code, PFM_SENSE_PRED_FAIL);
        results;
    end
endmodule : pfm_monitor_bench
`default_nettype wire
